// ---- shared/clc_pkg.sv ----
/*
  clc_pkg: configuration layout, selector encodings and timing constants of
  the configurable logic cell.
  assumes: configuration words are loaded before reset release and stay put.
*/
`default_nettype none

package clc_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int CLC_FIRST_INPUTS  = 4;
  localparam int CLC_SECOND_INPUTS = 4;
  localparam int CLC_COMB_INPUTS   = 3;
  localparam int CLC_FIRST_ENTRIES = 16;
  localparam int CLC_COMB_ENTRIES  = 8;
  localparam int CLC_CTRL_INPUTS   = 4;
  localparam int CLC_ELEMENTS      = 2;
  localparam int CLC_SYNC_STAGES   = 3;

  // ************************************************************
  // combining-table input positions
  // ************************************************************
  localparam int CLC_COMB_BIT_ZERO = 0;
  localparam int CLC_COMB_BIT_ONE  = 1;
  localparam int CLC_COMB_BIT_TWO  = 2;

  // ************************************************************
  // storage data selector encodings
  // ************************************************************
  localparam logic [1:0] CLC_DSEL_FIRST  = 2'h0;
  localparam logic [1:0] CLC_DSEL_SECOND = 2'h1;
  localparam logic [1:0] CLC_DSEL_COMB   = 2'h2;
  localparam logic [1:0] CLC_DSEL_DIRECT = 2'h3;

  // ************************************************************
  // two-way selector encodings
  // ************************************************************
  localparam logic CLC_OSEL_OWN_TABLE = 1'h0;
  localparam logic CLC_OSEL_COMB      = 1'h1;
  localparam logic CLC_CSEL_TABLE     = 1'h0;
  localparam logic CLC_CSEL_CONTROL   = 1'h1;

  // ************************************************************
  // reset values and variant
  // ************************************************************
  localparam logic CLC_Q_RESET        = 1'h0;
  localparam logic CLC_LEVEL_RESET    = 1'h0;
  localparam logic CLC_INIT_RESET     = 1'h0;
  localparam logic CLC_INIT_SET       = 1'h1;
  // low-voltage variant: latch option honoured
  localparam logic CLC_LATCH_AVAILABLE = 1'h1;

  // ************************************************************
  // configuration types
  // ************************************************************
  typedef struct packed {
    logic [1:0] data_sel;
    logic       clock_invert;
    logic       init_set;
    logic       latch_mode;
  } clc_elem_cfg_t;

  typedef struct packed {
    logic [CLC_FIRST_ENTRIES-1:0] first_table_bits;
    logic [CLC_FIRST_ENTRIES-1:0] second_table_bits;
    logic [CLC_COMB_ENTRIES-1:0]  combining_table_bits;
    logic                         comb_zero_sel;
    logic                         comb_two_sel;
    logic                         out_first_sel;
    logic                         out_second_sel;
    logic [1:0]                   pick_enable;
    logic [1:0]                   pick_set_reset;
    logic [1:0]                   pick_direct;
    logic [1:0]                   pick_comb_one;
    logic                         enable_used;
    logic                         set_reset_used;
    clc_elem_cfg_t [CLC_ELEMENTS-1:0] elem;
  } clc_cfg_t;

  typedef struct packed {
    logic enable;
    logic set_reset;
    logic direct;
    logic comb_one;
  } clc_ctrl_t;

endpackage : clc_pkg

`default_nettype wire

// ---- logic/clc_store.sv ----
/*
  clc_store: one storage element of the cell, edge register or latch.
  assumes: clock edges and levels arrive already synchronised and edge
  detected from the main cell on the same system clock.
*/
`default_nettype none

module clc_store
  import clc_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire clc_elem_cfg_t cfg,
  input  wire logic          d,
  input  wire logic          clk_level,
  input  wire logic          clk_rise,
  input  wire logic          clk_fall,
  input  wire logic          enable,
  input  wire logic          set_reset,
  input  wire logic          global_set_reset,
  input  wire logic          load,
  output logic               q
);

  typedef struct packed {
    logic q;
  } clc_store_state_t;

  clc_store_state_t state_r;
  clc_store_state_t state_nxt;
  logic             init_value;
  logic             eff_level;
  logic             eff_edge;
  logic             as_latch;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    state_nxt  = state_r;
    init_value = cfg.init_set ? CLC_INIT_SET : CLC_INIT_RESET;
    eff_level  = clk_level ^ cfg.clock_invert;
    eff_edge   = cfg.clock_invert ? clk_fall : clk_rise;
    as_latch   = cfg.latch_mode & CLC_LATCH_AVAILABLE;
    if (load || global_set_reset) begin
      state_nxt.q = init_value;
    end else if (set_reset) begin
      // set/reset beats clock and enable
      state_nxt.q = init_value;
    end else if (as_latch) begin
      // open while the effective clock is low, closed while high
      if (!eff_level && enable) begin
        state_nxt.q = d;
      end
    end else if (eff_edge && enable) begin
      state_nxt.q = d;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r.q <= CLC_Q_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign q = state_r.q;

endmodule : clc_store

`default_nettype wire

// ---- logic/clc_cell.sv ----
/*
  clc_cell: configurable logic cell with two four-input tables, a
  three-input combining table, output selectors and two storage elements.
  assumes: configuration is static after reset release; table and control
  inputs come from logic on the same clock; cell_clock comes from elsewhere
  and is synchronised here.
  the unused enable and set/reset defaults reach the storage elements only;
  the combining table always sees the picked control lines.
*/
`default_nettype none

module clc_cell
  import clc_pkg::*;
(
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire clc_cfg_t                     cfg,
  input  wire logic [CLC_FIRST_INPUTS-1:0]  first_table_inputs,
  input  wire logic [CLC_SECOND_INPUTS-1:0] second_table_inputs,
  input  wire logic [CLC_CTRL_INPUTS-1:0]   general_control_inputs,
  input  wire logic                         cell_clock,
  input  wire logic                         global_set_reset,
  output logic                              out_first,
  output logic                              out_second,
  output logic [CLC_ELEMENTS-1:0]           stored
);

  // ************************************************************
  // helpers
  // ************************************************************
  // table read; the contents are configuration, never written here
  function automatic logic lut_read(
    input logic [CLC_FIRST_ENTRIES-1:0] bits,
    input logic [3:0]                   addr
  );
    lut_read = bits[addr];
  endfunction : lut_read

  function automatic logic ctl_pick(
    input logic [CLC_CTRL_INPUTS-1:0] ins,
    input logic [1:0]                 sel
  );
    ctl_pick = ins[sel];
  endfunction : ctl_pick

  function automatic logic comb_read(
    input logic [CLC_COMB_ENTRIES-1:0] bits,
    input logic [CLC_COMB_INPUTS-1:0]  addr
  );
    comb_read = bits[addr];
  endfunction : comb_read

  // combining inputs zero and two: table output or control line
  function automatic logic comb_in_pick(
    input logic sel,
    input logic table_out,
    input logic control
  );
    if (sel == CLC_CSEL_CONTROL) begin
      comb_in_pick = control;
    end else begin
      comb_in_pick = table_out;
    end
  endfunction : comb_in_pick

  // a registered output shows its own table or the combining table
  function automatic logic out_pick(
    input logic sel,
    input logic own_out,
    input logic comb
  );
    if (sel == CLC_OSEL_COMB) begin
      out_pick = comb;
    end else begin
      out_pick = own_out;
    end
  endfunction : out_pick

  // a settled level that differs from the held one is an edge
  function automatic logic level_edge(
    input logic agree,
    input logic now_level,
    input logic was_level,
    input logic to_high
  );
    level_edge = agree && (now_level != was_level) && (now_level == to_high);
  endfunction : level_edge

  function automatic logic data_pick(
    input logic [1:0] sel,
    input logic       f,
    input logic       g,
    input logic       h,
    input logic       dir
  );
    case (sel)
      CLC_DSEL_FIRST:  data_pick = f;
      CLC_DSEL_SECOND: data_pick = g;
      CLC_DSEL_COMB:   data_pick = h;
      default:         data_pick = dir;
    endcase
  endfunction : data_pick

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [CLC_SYNC_STAGES-1:0] clk_sync;
    logic                       clk_level;
    logic                       loaded;
    logic                       out_first;
    logic                       out_second;
  } clc_cell_state_t;

  clc_cell_state_t               state_r;
  clc_cell_state_t               state_nxt;
  clc_ctrl_t                     ctrl;
  logic                          first_out;
  logic                          second_out;
  logic                          comb_out;
  logic [CLC_COMB_INPUTS-1:0]    comb_addr;
  logic                          clk_agree;
  logic                          clk_rise;
  logic                          clk_fall;
  logic [CLC_ELEMENTS-1:0]       elem_d;
  logic                          elem_enable;
  logic                          elem_set_reset;
  logic [CLC_SYNC_STAGES-1:0]    sync_shift;

  // ************************************************************
  // control pickers
  // ************************************************************
  // no inversion option exists for enable or set/reset
  always_comb begin
    ctrl.enable    = ctl_pick(general_control_inputs, cfg.pick_enable);
    ctrl.set_reset = ctl_pick(general_control_inputs, cfg.pick_set_reset);
    ctrl.direct    = ctl_pick(general_control_inputs, cfg.pick_direct);
    ctrl.comb_one  = ctl_pick(general_control_inputs, cfg.pick_comb_one);
  end

  // ************************************************************
  // element controls
  // ************************************************************
  // gating here, not in the pickers, keeps the picked set/reset usable
  // as combining input zero while the elements ignore it
  always_comb begin
    elem_enable    = ctrl.enable;
    elem_set_reset = ctrl.set_reset;
    if (!cfg.enable_used) begin
      elem_enable = 1'h1;
    end
    if (!cfg.set_reset_used) begin
      elem_set_reset = 1'h0;
    end
  end

  // ************************************************************
  // function tables
  // ************************************************************
  always_comb begin
    first_out  = lut_read(cfg.first_table_bits, first_table_inputs);
    second_out = lut_read(cfg.second_table_bits,
                          second_table_inputs);
    comb_addr[CLC_COMB_BIT_ZERO] = comb_in_pick(cfg.comb_zero_sel, first_out,
                                                ctrl.set_reset);
    comb_addr[CLC_COMB_BIT_ONE]  = ctrl.comb_one;
    comb_addr[CLC_COMB_BIT_TWO]  = comb_in_pick(cfg.comb_two_sel, second_out,
                                                ctrl.direct);
    // feeding both table outputs in gives five-input and wider functions
    comb_out = comb_read(cfg.combining_table_bits,
                         comb_addr);
  end

  // ************************************************************
  // cell clock synchroniser and edge detect
  // ************************************************************
  // the first stage feeds only the second; the level moves once the
  // second and third stages agree
  assign sync_shift[0] = cell_clock;
  generate
    for (genvar s = 1; s < CLC_SYNC_STAGES; s++) begin : g_sync
      assign sync_shift[s] = state_r.clk_sync[s-1];
    end
  endgenerate

  assign clk_agree = state_r.clk_sync[1] == state_r.clk_sync[2];
  assign clk_rise  = level_edge(clk_agree, state_r.clk_sync[1],
                                state_r.clk_level, 1'h1);
  assign clk_fall  = level_edge(clk_agree, state_r.clk_sync[1],
                                state_r.clk_level, 1'h0);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    state_nxt.clk_sync = sync_shift;
    if (clk_agree) begin
      state_nxt.clk_level = state_r.clk_sync[1];
    end
    state_nxt.loaded = 1'h1;
    // outputs are registered: a third function leaves via either output selector or via storage
    state_nxt.out_first  = out_pick(cfg.out_first_sel, first_out,
                                    comb_out);
    state_nxt.out_second = out_pick(cfg.out_second_sel, second_out,
                                    comb_out);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r.clk_sync   <= '0;
      state_r.clk_level  <= CLC_LEVEL_RESET;
      state_r.loaded     <= 1'h0;
      state_r.out_first  <= 1'h0;
      state_r.out_second <= 1'h0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // storage elements
  // ************************************************************
  // both share clock, enable and set/reset; each has its own options
  generate
    for (genvar e = 0; e < CLC_ELEMENTS; e++) begin : g_elem
      assign elem_d[e] = data_pick(cfg.elem[e].data_sel, first_out,
                                   second_out, comb_out,
                                   ctrl.direct);
      clc_store u_store (
        .clock            (clock),
        .rst_n            (rst_n),
        .cfg              (cfg.elem[e]),
        .d                (elem_d[e]),
        .clk_level        (state_nxt.clk_level),
        .clk_rise         (clk_rise),
        .clk_fall         (clk_fall),
        .enable           (elem_enable),
        .set_reset        (elem_set_reset),
        .global_set_reset (global_set_reset),
        .load             (~state_r.loaded),
        .q                (stored[e])
      );
    end
  endgenerate

  assign out_first  = state_r.out_first;
  assign out_second = state_r.out_second;

endmodule : clc_cell

`default_nettype wire

// ---- tb/clc_fabric.sv ----
/*
  clc_fabric: routing fabric model driving the shared cell clock line.
  assumes: toggle_req is a one-cycle pulse on the system clock.
*/
`default_nettype none

module clc_fabric (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic toggle_req,
  input  wire logic slow,
  output logic      cell_clock
);
  // ************************************************************
  // clock line
  // ************************************************************
  logic [1:0] wait_r;
  logic       pend_r;

  // line rests between requests; slow mode lags three cycles
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cell_clock <= 1'b0;
      pend_r     <= 1'b0;
      wait_r     <= 2'h0;
    end else if (toggle_req) begin
      pend_r <= 1'b1;
      wait_r <= slow ? 2'h3 : 2'h0;
    end else if (pend_r && wait_r == 2'h0) begin
      pend_r     <= 1'b0;
      cell_clock <= ~cell_clock;
    end else if (pend_r) begin
      wait_r <= wait_r - 2'h1;
    end
  end
endmodule : clc_fabric

`default_nettype wire

// ---- tb/clc_cell_sva.sv ----
/*
  clc_cell_sva: port checks of the logic cell.
  assumes: cfg stays put while rst_n is high.
*/
`default_nettype none

module clc_cell_sva
  import clc_pkg::*;
(
  input wire logic                         clock,
  input wire logic                         rst_n,
  input wire clc_cfg_t                     cfg,
  input wire logic [CLC_FIRST_INPUTS-1:0]  first_table_inputs,
  input wire logic [CLC_SECOND_INPUTS-1:0] second_table_inputs,
  input wire logic [CLC_CTRL_INPUTS-1:0]   general_control_inputs,
  input wire logic                         cell_clock,
  input wire logic                         global_set_reset,
  input wire logic                         out_first,
  input wire logic                         out_second,
  input wire logic [CLC_ELEMENTS-1:0]      stored
);
  // ************************************************************
  // helpers and properties
  // ************************************************************
  logic [3:0] c;
  logic [1:0] up_r, init_v;
  logic [2:0] h_a;
  logic       f_v, g_v, h_v, sr_v, en_v;
  assign c = general_control_inputs;
  assign f_v = cfg.first_table_bits[first_table_inputs];
  assign g_v = cfg.second_table_bits[second_table_inputs];
  assign h_a = {cfg.comb_two_sel ? c[cfg.pick_direct] : g_v,
                c[cfg.pick_comb_one],
                cfg.comb_zero_sel ? c[cfg.pick_set_reset] : f_v};
  assign h_v = cfg.combining_table_bits[h_a];
  assign sr_v = cfg.set_reset_used & c[cfg.pick_set_reset];
  assign en_v = ~cfg.enable_used | c[cfg.pick_enable];
  assign init_v = {cfg.elem[1].init_set, cfg.elem[0].init_set};

  // outputs lag inputs by one edge, so skip the first edges
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_quiet;
    up_r == 2'h3 && !sr_v && !global_set_reset;
  endsequence

  AST_FIRST_OWN: assert property (up_r == 2'h3 && !cfg.out_first_sel
    |-> out_first == $past(f_v)) else $error("first output wrong");
  AST_SECOND_OWN: assert property (up_r == 2'h3 && !cfg.out_second_sel
    |-> out_second == $past(g_v)) else $error("second output wrong");
  AST_FIRST_COMB: assert property (up_r == 2'h3 && cfg.out_first_sel
    |-> out_first == $past(h_v)) else $error("first combined wrong");
  AST_SECOND_COMB: assert property (up_r == 2'h3 && cfg.out_second_sel
    |-> out_second == $past(h_v)) else $error("second combined wrong");
  AST_SET_RESET: assert property (sr_v |=> stored == init_v)
    else $error("set/reset did not force value");
  AST_GLOBAL: assert property (global_set_reset |=> stored == init_v)
    else $error("global set/reset did not force value");
  AST_INIT: assert property (up_r == 2'h1 |-> stored == init_v)
    else $error("start value wrong");
  AST_ENABLE_HOLD: assert property ((s_quiet and !en_v)
    |=> $stable(stored)) else $error("stored moved while disabled");
endmodule : clc_cell_sva

bind clc_cell clc_cell_sva clc_cell_sva_inst (
  .clock(clock), .rst_n(rst_n), .cfg(cfg),
  .first_table_inputs(first_table_inputs),
  .second_table_inputs(second_table_inputs),
  .general_control_inputs(general_control_inputs),
  .cell_clock(cell_clock), .global_set_reset(global_set_reset),
  .out_first(out_first), .out_second(out_second), .stored(stored));

`default_nettype wire

// ---- tb/tb.sv ----
/*
  tb: self-checking bench of the logic cell.
  assumes: clc_fabric drives the cell clock; cfg changes only in reset.
*/
`default_nettype none

module tb
  import clc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // stimulus and tasks
  // ************************************************************
  logic       clock = 1'b0, rst_n = 1'b0, global_set_reset = 1'b0;
  logic       toggle_req = 1'b0, slow = 1'b0, cell_clock;
  logic       out_first, out_second;
  logic [3:0] fin = 4'h0, sin = 4'h0, gci = 4'h0;
  logic [1:0] stored;
  clc_cfg_t   cfg = '0, c = '0;
  int         mismatches = 0, n_checks = 0, cycles = 0;

  always #20 clock = ~clock;

  clc_cell clc_cell_inst (.clock(clock), .rst_n(rst_n), .cfg(cfg),
    .first_table_inputs(fin), .second_table_inputs(sin),
    .general_control_inputs(gci), .cell_clock(cell_clock),
    .global_set_reset(global_set_reset), .out_first(out_first),
    .out_second(out_second), .stored(stored));
  clc_fabric clc_fabric_inst (.clock(clock), .rst_n(rst_n),
    .toggle_req(toggle_req), .slow(slow), .cell_clock(cell_clock));

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [1:0] e,
                     input logic [1:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // configuration is only legal while the cell is held in reset
  task automatic restart();
    @(negedge clock);
    rst_n = 1'b0;
    cfg = c;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
  endtask : restart

  task automatic drive(input logic [3:0] f, input logic [3:0] cc);
    @(negedge clock);
    fin = f;
    sin = ~f;
    gci = cc;
    @(negedge clock);
  endtask : drive

  // synchroniser plus lag needs well under 13 cycles to settle
  task automatic cell_edge(input logic s);
    @(negedge clock);
    slow = s;
    toggle_req = 1'b1;
    @(negedge clock);
    toggle_req = 1'b0;
    repeat (12) @(negedge clock);
  endtask : cell_edge

  function automatic logic exp_comb();
    logic [2:0] a;
    a[0] = cfg.comb_zero_sel ? gci[cfg.pick_set_reset]
                             : cfg.first_table_bits[fin];
    a[1] = gci[cfg.pick_comb_one];
    a[2] = cfg.comb_two_sel ? gci[cfg.pick_direct]
                            : cfg.second_table_bits[sin];
    return cfg.combining_table_bits[a];
  endfunction : exp_comb

  initial begin
    c.first_table_bits = 16'hA5C3;
    c.second_table_bits = 16'h3C96;
    c.combining_table_bits = 8'hD2;
    restart();
    for (int i = 0; i < 16; i++) begin
      drive(i[3:0], 4'h0);
      chk("tables", {cfg.first_table_bits[fin], cfg.second_table_bits[sin]},
          {out_first, out_second});
    end
    $display("test tables done");
    c.out_first_sel = CLC_OSEL_COMB;
    c.out_second_sel = CLC_OSEL_COMB;
    for (int j = 0; j < 3; j++) begin
      c.comb_zero_sel = (j != 0);
      c.comb_two_sel = (j != 0);
      c.pick_set_reset = 2'(j);
      c.pick_comb_one = 2'(j + 1);
      c.pick_direct = 2'(j + 2);
      restart();
      for (int i = 0; i < 16; i++) begin
        drive(i[3:0], i[3:0] ^ 4'h5);
        chk("combined", {2{exp_comb()}},
            {out_first, out_second});
      end
    end
    $display("test combining done");
    c = {c.first_table_bits, c.second_table_bits, c.combining_table_bits,
         24'h0};
    c.pick_comb_one = 2'h1;
    c.pick_direct = 2'h2;
    c.pick_enable = 2'h3;
    c.enable_used = 1'b1;
    c.set_reset_used = 1'b1;
    c.elem[0] = '{CLC_DSEL_DIRECT, 1'b0, CLC_INIT_RESET, 1'b0};
    c.elem[1] = '{CLC_DSEL_FIRST, 1'b1, CLC_INIT_SET, 1'b0};
    restart();
    chk("start", 2'h2, stored);
    drive(4'h2, 4'hC);
    cell_edge(1'b0);
    chk("rise", 2'h3, stored);
    cell_edge(1'b1);
    chk("fall", 2'h1, stored);
    drive(4'h2, 4'h0);
    cell_edge(1'b0);
    chk("enable low", 2'h1, stored);
    drive(4'h2, 4'h1);
    chk("set reset", 2'h2, stored);
    drive(4'h2, 4'hC);
    cell_edge(1'b1);
    chk("second fall", 2'h0, stored);
    @(negedge clock);
    global_set_reset = 1'b1;
    @(negedge clock);
    global_set_reset = 1'b0;
    chk("global", 2'h2, stored);
    $display("test storage done");
    c.elem[0] = '{CLC_DSEL_DIRECT, 1'b0, CLC_INIT_RESET, 1'b1};
    c.enable_used = 1'b0;
    c.set_reset_used = 1'b0;
    restart();
    drive(4'h2, 4'h5);
    chk("latch open", 2'h3, stored);
    drive(4'h2, 4'h1);
    chk("latch follow", 2'h2, stored);
    cell_edge(1'b0);
    drive(4'h2, 4'h4);
    chk("latch closed", 2'h2, stored);
    $display("test latch done");
    c.elem[0] = '{CLC_DSEL_COMB, 1'b0, CLC_INIT_RESET, 1'b0};
    c.elem[1] = '{CLC_DSEL_SECOND, 1'b0, CLC_INIT_RESET, 1'b0};
    restart();
    drive(4'h2, 4'h2);
    chk("select start", 2'h0, stored);
    cell_edge(1'b0);
    chk("table data", 2'h3, stored);
    $display("test data select done");
    test_done();
  end
endmodule : tb

`default_nettype wire
